// ===== rtl/pbb_pkg.sv
/*
  Shared constants, types and field layouts of the peripheral board bus bridge.
  Assumes a 100 MHz board clock and the io processor's 20-bit local address map.
*/
package pbb_pkg;

  // ****************************************
  // local address map (io processor space)
  // ****************************************
  localparam logic [19:0] RAM_LAST = 20'h03FFF;
  localparam logic [19:0] PERIPH_BASE = 20'h04000;
  localparam logic [19:0] PERIPH_LAST = 20'h0407F;
  localparam logic [19:0] USART_BASE = 20'h06060;
  localparam logic [19:0] USART_LAST = 20'h06067;
  localparam logic [19:0] STATUS_ADDR = 20'h04018;
  localparam logic [19:0] CODE_SEG_ADDR = 20'h04068;
  localparam logic [19:0] DATA_SEG_ADDR = 20'h04070;
  localparam logic [19:0] TICK_CLR_ADDR = 20'h04078;
  localparam int PERIPH_IDX_LSB = 3;
  localparam logic [3:0] PAGE_IO_DS = 4'h1;
  localparam logic [3:0] PAGE_MEM_DS = 4'h3;
  localparam logic [3:0] PAGE_MEM_CS = 4'h7;

  // ****************************************
  // slave window
  // ****************************************
  localparam logic [15:0] HOST_CTRL_OFFSET = 16'h8000;
  localparam int HOST_CLR_RUN_BIT = 5;
  localparam int HOST_SET_DB_BIT = 1;

  // ****************************************
  // board status fields
  // ****************************************
  localparam int ST_RED = 7;
  localparam int ST_GREEN = 6;
  localparam int ST_RUN = 5;
  localparam int ST_TMO = 4;
  localparam int ST_ZERO = 3;
  localparam int ST_LOCK = 2;
  localparam int ST_HOST_DB = 1;
  localparam int ST_PROC_DB = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SEG_RESET = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_TIMEOUT_NS = 16000;
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_NS / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    K_NONE, K_RAM, K_DEV, K_USART, K_TICK, K_STATUS, K_CSEG, K_DSEG,
    K_BUS_IO_DS, K_BUS_MEM_DS, K_BUS_MEM_CS
  } pbb_kind_e;

  typedef struct packed {
    logic strobe;
    logic we;
    logic ram_sel;
    logic dev_sel;
    logic usart_sel;
    logic tick_clr;
    logic [3:0] dev_idx;
    logic [19:0] addr;
    logic [15:0] wdata;
  } pbb_local_s;

  typedef struct packed {
    logic req;
    logic lock;
    logic io;
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pbb_bus_s;

  typedef struct packed {
    logic grant;
    logic xack;
    logic other_req;
    logic slv_rd;
    logic slv_wr;
    logic [23:0] slv_addr;
    logic [15:0] slv_wdata;
    logic [15:0] bus_rdata;
    logic [7:0] win_base;
    logic strap_lock_en;
    logic strap_release_each;
    logic [2:0] strap_irq_level;
    logic [1:0] strap_a22_pos;
    logic [1:0] strap_a23_pos;
  } pbb_pins_s;

endpackage

// ===== rtl/pbb_bridge.sv
/*
  Peripheral board bus bridge: local decode for the io processor, system bus
  master cycles through segment registers, slave window for the host, board
  status register, doorbells and lamps.
  Assumes the io processor interface and local devices run on i_clk; every
  system bus pin and strap is asynchronous and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module pbb_bridge #(
  parameter int TIMEOUT_CYCLES = pbb_pkg::BUS_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // io processor
  input wire logic i_cpu_req,
  input wire logic i_cpu_we,
  input wire logic [19:0] i_cpu_addr,
  input wire logic [15:0] i_cpu_wdata,
  output logic o_cpu_ack,
  output logic [15:0] o_cpu_rdata,
  output logic o_iop_reset,
  output logic o_iop_nmi,
  output logic o_iop_doorbell,
  // local device bus
  output var pbb_pkg::pbb_local_s o_local,
  input wire logic [15:0] i_local_rdata,
  // system bus pins and straps
  input wire pbb_pkg::pbb_pins_s i_pins,
  output var pbb_pkg::pbb_bus_s o_bus,
  output logic o_slv_xack,
  output logic [15:0] o_slv_rdata,
  output logic [7:0] o_host_irq,
  // auxiliary connector
  output logic o_aux_a20,
  output logic o_aux_a21,
  output logic [1:0] o_aux_a22,
  output logic [1:0] o_aux_a23,
  // lamps
  output logic o_lamp_red,
  output logic o_lamp_green,
  output logic o_lamp_halt
);
  import pbb_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] TMO_LAST = CW'(TIMEOUT_CYCLES - 1);

  initial begin
    if (TIMEOUT_CYCLES < 2) begin
      $error("TIMEOUT_CYCLES must be at least 2");
    end
  end

  // ****************************************
  // pin synchroniser
  // ****************************************
  pbb_pins_s pin_meta;
  pbb_pins_s pin;
  logic slv_cmd_prev;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta <= '0;
      pin <= '0;
    end else begin
      pin_meta <= i_pins;
      pin <= pin_meta;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  function automatic pbb_kind_e decode(input logic [19:0] a);
    pbb_kind_e k;
    k = K_NONE;
    if (a <= RAM_LAST) begin
      k = K_RAM;
    end else if (a == STATUS_ADDR) begin
      k = K_STATUS;
    end else if (a == CODE_SEG_ADDR) begin
      k = K_CSEG;
    end else if (a == DATA_SEG_ADDR) begin
      k = K_DSEG;
    end else if (a == TICK_CLR_ADDR) begin
      k = K_TICK;
    end else if (a >= PERIPH_BASE && a <= PERIPH_LAST && a[2:0] == 3'h0) begin
      k = K_DEV;
    end else if (a >= USART_BASE && a <= USART_LAST) begin
      k = K_USART;
    end else if (a[19:16] == PAGE_IO_DS) begin
      k = K_BUS_IO_DS;
    end else if (a[19:16] == PAGE_MEM_DS) begin
      k = K_BUS_MEM_DS;
    end else if (a[19:16] == PAGE_MEM_CS) begin
      k = K_BUS_MEM_CS;
    end
    return k;
  endfunction

  function automatic logic is_bus(input pbb_kind_e k);
    return k == K_BUS_IO_DS || k == K_BUS_MEM_DS || k == K_BUS_MEM_CS;
  endfunction

  // ****************************************
  // state and registers
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_ARB, ST_CYC} pbb_state_e;
  pbb_state_e state;
  logic lamp_red, lamp_green, run_en, tmo, lock, host_db, proc_db;
  logic [7:0] code_seg, data_seg;
  logic bus_own;
  logic [CW-1:0] tmo_cnt;
  logic [19:0] cur_addr;
  logic cur_we;
  logic [15:0] cur_wdata;
  pbb_kind_e cur_kind;
  logic [1:0] slv_phase;
  logic [19:0] slv_laddr;
  pbb_kind_e slv_kind;

  wire [7:0] status_rd = {lamp_red, lamp_green, run_en, tmo, 1'b0, lock, host_db, proc_db};
  wire pbb_kind_e cpu_kind = decode(i_cpu_addr);
  wire cpu_take = state == ST_IDLE && run_en && i_cpu_req;
  wire lock_eff = lock && pin.strap_lock_en;

  // slave window
  wire slv_cmd = pin.slv_rd || pin.slv_wr;
  wire win_hit = pin.slv_addr[23:16] == pin.win_base && !bus_own;
  wire ctrl_hit = pin.slv_addr[15:0] == HOST_CTRL_OFFSET && pin.slv_wr;
  wire [19:0] slv_map = {4'h0, 1'b0, pin.slv_addr[14:0]};
  wire slv_general = !run_en && !ctrl_hit;
  wire slv_go = slv_cmd && win_hit && (slv_general || ctrl_hit) && slv_phase == 2'd0;
  wire host_ctrl_wr = slv_go && ctrl_hit;
  wire host_clr_run = host_ctrl_wr && pin.slv_wdata[HOST_CLR_RUN_BIT];
  wire host_set_db = host_ctrl_wr && pin.slv_wdata[HOST_SET_DB_BIT];
  wire slv_local = slv_go && !ctrl_hit;
  wire pbb_kind_e slv_dec = decode(slv_map);

  // status writes from processor or host window
  wire cpu_st_wr = cpu_take && i_cpu_we && cpu_kind == K_STATUS;
  wire slv_st_wr = slv_local && pin.slv_wr && slv_dec == K_STATUS;
  wire st_wr = cpu_st_wr || slv_st_wr;
  wire [7:0] st_wdata = cpu_st_wr ? i_cpu_wdata[7:0] : pin.slv_wdata[7:0];
  wire seg_wr_c = (cpu_take && i_cpu_we && cpu_kind == K_CSEG) ||
    (slv_local && pin.slv_wr && slv_dec == K_CSEG);
  wire seg_wr_d = (cpu_take && i_cpu_we && cpu_kind == K_DSEG) ||
    (slv_local && pin.slv_wr && slv_dec == K_DSEG);

  // timeout events
  wire tmo_missing = cpu_take && cpu_kind == K_NONE;
  wire tmo_bus = state == ST_CYC && !pin.xack && tmo_cnt == TMO_LAST;
  wire tmo_event = tmo_missing || tmo_bus;

  // release of an idle owned bus
  wire release_now = !lock_eff && (pin.strap_release_each || pin.other_req);

  // ****************************************
  // status register
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {lamp_red, lamp_green, run_en, tmo} <= STATUS_RESET[7:4];
      {lock, host_db, proc_db} <= STATUS_RESET[2:0];
      code_seg <= SEG_RESET;
      data_seg <= SEG_RESET;
    end else begin
      if (st_wr) begin
        lamp_red <= st_wdata[ST_RED];
        lamp_green <= st_wdata[ST_GREEN];
        lock <= st_wdata[ST_LOCK];
        host_db <= st_wdata[ST_HOST_DB];
      end
      // host clear of run enable wins over a write setting it
      if (host_clr_run) begin
        run_en <= 1'b0;
      end else if (st_wr) begin
        run_en <= st_wdata[ST_RUN];
      end
      // set wins over clear for the doorbell and the timeout flag
      if (host_set_db) begin
        proc_db <= 1'b1;
      end else if (st_wr) begin
        proc_db <= st_wdata[ST_PROC_DB];
      end
      if (tmo_event) begin
        tmo <= 1'b1;
      end else if (st_wr) begin
        tmo <= 1'b0;
      end
      if (seg_wr_c) begin
        code_seg <= cpu_take ? i_cpu_wdata[7:0] : pin.slv_wdata[7:0];
      end
      if (seg_wr_d) begin
        data_seg <= cpu_take ? i_cpu_wdata[7:0] : pin.slv_wdata[7:0];
      end
    end
  end

  // ****************************************
  // processor side and bus master
  // ****************************************
  function automatic logic [15:0] reg_read(input pbb_kind_e k, input logic [15:0] ext);
    logic [15:0] r;
    r = ext;
    case (k)
      K_STATUS: r = {8'h00, status_rd};
      K_CSEG: r = {8'h00, code_seg};
      K_DSEG: r = {8'h00, data_seg};
      default: r = ext;
    endcase
    return r;
  endfunction

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_IDLE;
      bus_own <= 1'b0;
      tmo_cnt <= '0;
      cur_addr <= '0;
      cur_we <= 1'b0;
      cur_wdata <= '0;
      cur_kind <= K_NONE;
      o_cpu_ack <= 1'b0;
      o_cpu_rdata <= '0;
      o_iop_nmi <= 1'b0;
      o_bus <= '0;
    end else begin
      o_cpu_ack <= 1'b0;
      o_iop_nmi <= tmo_event;
      o_bus.rd <= 1'b0;
      o_bus.wr <= 1'b0;
      o_bus.req <= (state != ST_IDLE && state != ST_LOCAL) || bus_own;
      o_bus.lock <= lock_eff && bus_own;
      tmo_cnt <= '0;
      if (!run_en) begin
        // processor held in reset: slave only
        state <= ST_IDLE;
        bus_own <= 1'b0;
        o_bus.req <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (bus_own && release_now && !cpu_take) begin
              bus_own <= 1'b0;
            end
            if (cpu_take) begin
              cur_addr <= i_cpu_addr;
              cur_we <= i_cpu_we;
              cur_wdata <= i_cpu_wdata;
              cur_kind <= cpu_kind;
              if (cpu_kind == K_NONE) begin
                o_cpu_ack <= 1'b1;
                o_cpu_rdata <= '0;
              end else if (is_bus(cpu_kind)) begin
                state <= ST_ARB;
              end else begin
                state <= ST_LOCAL;
              end
            end
          end
          ST_LOCAL: begin
            o_cpu_ack <= 1'b1;
            o_cpu_rdata <= reg_read(cur_kind, i_local_rdata);
            state <= ST_IDLE;
          end
          ST_ARB: begin
            o_bus.req <= 1'b1;
            if (bus_own || pin.grant) begin
              bus_own <= 1'b1;
              o_bus.io <= cur_kind == K_BUS_IO_DS;
              o_bus.addr <= {cur_kind == K_BUS_MEM_CS ? code_seg : data_seg,
                cur_addr[15:0]};
              o_bus.wdata <= cur_wdata;
              state <= ST_CYC;
            end
          end
          ST_CYC: begin
            o_bus.rd <= !cur_we && !pin.xack && !tmo_bus;
            o_bus.wr <= cur_we && !pin.xack && !tmo_bus;
            tmo_cnt <= tmo_cnt + CW'(1);
            if (pin.xack || tmo_bus) begin
              o_cpu_ack <= 1'b1;
              o_cpu_rdata <= pin.xack ? pin.bus_rdata : 16'h0000;
              if (pin.strap_release_each && !lock_eff) begin
                bus_own <= 1'b0;
              end
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // slave side and local bus
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      slv_phase <= 2'd0;
      slv_laddr <= '0;
      slv_kind <= K_NONE;
      slv_cmd_prev <= 1'b0;
      o_slv_xack <= 1'b0;
      o_slv_rdata <= '0;
      o_local <= '0;
    end else begin
      slv_cmd_prev <= slv_cmd;
      o_local.strobe <= 1'b0;
      case (slv_phase)
        2'd0: begin
          if (slv_go) begin
            slv_laddr <= slv_map;
            slv_kind <= slv_dec;
            slv_phase <= ctrl_hit ? 2'd2 : 2'd1;
            o_slv_xack <= ctrl_hit;
          end
        end
        2'd1: begin
          o_slv_rdata <= reg_read(slv_kind, i_local_rdata);
          o_slv_xack <= 1'b1;
          slv_phase <= 2'd2;
        end
        2'd2: begin
          if (!slv_cmd) begin
            o_slv_xack <= 1'b0;
            slv_phase <= 2'd0;
          end
        end
        default: slv_phase <= 2'd0;
      endcase
      // one-cycle strobe on the shared local bus
      if (cpu_take && !is_bus(cpu_kind) && cpu_kind != K_NONE) begin
        o_local.strobe <= 1'b1;
        o_local.we <= i_cpu_we;
        o_local.addr <= i_cpu_addr;
        o_local.wdata <= i_cpu_wdata;
        o_local.ram_sel <= cpu_kind == K_RAM;
        o_local.dev_sel <= cpu_kind == K_DEV;
        o_local.usart_sel <= cpu_kind == K_USART;
        o_local.tick_clr <= cpu_kind == K_TICK && i_cpu_we;
        o_local.dev_idx <= i_cpu_addr[PERIPH_IDX_LSB +: 4];
      end else if (slv_local) begin
        o_local.strobe <= 1'b1;
        o_local.we <= pin.slv_wr;
        o_local.addr <= slv_map;
        o_local.wdata <= pin.slv_wdata;
        o_local.ram_sel <= slv_dec == K_RAM;
        o_local.dev_sel <= slv_dec == K_DEV;
        o_local.usart_sel <= slv_dec == K_USART;
        o_local.tick_clr <= slv_dec == K_TICK && pin.slv_wr;
        o_local.dev_idx <= slv_map[PERIPH_IDX_LSB +: 4];
      end
    end
  end

  // ****************************************
  // lamps, interrupts, aux address
  // ****************************************
  assign o_iop_reset = !run_en;
  assign o_iop_doorbell = proc_db;
  assign o_host_irq = host_db ? (8'h01 << pin.strap_irq_level) : 8'h00;
  assign o_lamp_red = lamp_red;
  assign o_lamp_green = lamp_green;
  assign o_lamp_halt = !run_en;
  // lines only carry bits while the board owns the bus
  assign o_aux_a20 = o_bus.addr[20] && bus_own;
  assign o_aux_a21 = o_bus.addr[21] && bus_own;
  assign o_aux_a22 = {2{o_bus.addr[22] && bus_own}} & pin.strap_a22_pos;
  assign o_aux_a23 = {2{o_bus.addr[23] && bus_own}} & pin.strap_a23_pos;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_ram_req;
    cpu_take && cpu_kind == K_RAM;
  endsequence
  property p_ram_sel;
    @(posedge i_clk) disable iff (i_reset)
    s_ram_req |=> o_local.strobe && o_local.ram_sel ##1 o_cpu_ack;
  endproperty
  a_ram_sel: assert property (p_ram_sel) else $error("ram access not decoded");

  property p_tick;
    @(posedge i_clk) disable iff (i_reset)
    cpu_take && i_cpu_we && i_cpu_addr == TICK_CLR_ADDR |=> o_local.tick_clr;
  endproperty
  a_tick: assert property (p_tick) else $error("tick clear not decoded");

  property p_bus_addr;
    @(posedge i_clk) disable iff (i_reset)
    (o_bus.rd || o_bus.wr) |-> o_bus.addr[15:0] == cur_addr[15:0] &&
      o_bus.addr[23:16] == (cur_kind == K_BUS_MEM_CS ? code_seg : data_seg);
  endproperty
  a_bus_addr: assert property (p_bus_addr) else $error("bus address mismatch");

  property p_no_req_reset;
    @(posedge i_clk) disable iff (i_reset)
    !run_en [*2] |-> !o_bus.req;
  endproperty
  a_no_req_reset: assert property (p_no_req_reset) else $error("bus request in reset");

  sequence s_host_clear;
    host_clr_run ##1 1'b1;
  endsequence
  property p_host_clear;
    @(posedge i_clk) disable iff (i_reset)
    s_host_clear |-> !run_en && o_lamp_halt && o_iop_reset;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("host clear ignored");

  property p_host_db;
    @(posedge i_clk) disable iff (i_reset)
    host_set_db |=> o_iop_doorbell;
  endproperty
  a_host_db: assert property (p_host_db) else $error("doorbell not set");

  property p_bus_tmo;
    @(posedge i_clk) disable iff (i_reset)
    state == ST_CYC && tmo_cnt == TMO_LAST && !pin.xack |=> tmo && o_iop_nmi && o_cpu_ack;
  endproperty
  a_bus_tmo: assert property (p_bus_tmo) else $error("bus timeout missed");

  property p_tmo_clear;
    @(posedge i_clk) disable iff (i_reset)
    st_wr && !tmo_event |=> !tmo;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("timeout not cleared");

  property p_slave_refuse;
    @(posedge i_clk) disable iff (i_reset)
    slv_phase == 2'd0 && run_en && !ctrl_hit |=> !o_slv_xack;
  endproperty
  a_slave_refuse: assert property (p_slave_refuse) else $error("slave access while running");

endmodule

`default_nettype wire

// ===== sim/pbb_host_model.sv
/*
  Far side of the bridge: arbiter grant, other bus slaves and the host master.
  Assumes the bench ORs its straps with o_pins and calls host() after an edge.
*/
`timescale 1ns/1ns
`default_nettype none
module pbb_host_model
  import pbb_pkg::*;
(
  // board side
  input wire logic i_clk,
  input wire pbb_pkg::pbb_bus_s i_bus,
  input wire logic [7:0] i_win,
  input wire logic i_xack,
  input wire logic [15:0] i_rdata,
  // bus side
  output var pbb_pkg::pbb_pins_s o_pins
);
  pbb_pins_s h = '0;
  int cnt = 0;
  int slow = 3;
  assign o_pins = h;
  always @(posedge i_clk) begin
    #1;
    h.grant = i_bus.req;
    cnt = (i_bus.rd | i_bus.wr) ? cnt + 1 : 0;
    // nothing else answers inside the board's own window
    h.xack = cnt > slow && i_bus.addr[23:16] !== i_win;
    h.bus_rdata = h.xack ? i_bus.addr[15:0] ^ 16'h5A5A : ~h.bus_rdata;
  end
  // general access only while the processor is held, t_stop tries one while running
  task automatic host(input logic wr, input logic [23:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    int n;
    ok = 0;
    h.slv_addr = a;
    h.slv_wdata = d;
    h.slv_wr = wr;
    h.slv_rd = !wr;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge i_clk);
      ok = i_xack;
      q = i_rdata;
    end
    #1;
    h.slv_wr = 0;
    h.slv_rd = 0;
    h.slv_addr = ~a;
    h.slv_wdata = ~d;
    for (n = 0; n < 8 && i_xack; n++) begin
      @(posedge i_clk);
    end
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_pbb_bridge.sv
/*
  Self-checking bench of the bus bridge: host window, processor map, bus cycles.
  Assumes pbb_host_model as far side and a timeout shortened to 8 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module test_pbb_bridge;
  import pbb_pkg::*;
  localparam logic [7:0] WB = 8'h2A;
  logic i_clk = 0;
  logic i_reset = 1;
  logic i_cpu_req = 0;
  logic i_cpu_we = 0;
  logic [19:0] i_cpu_addr = '0;
  logic [15:0] i_cpu_wdata = '0;
  logic o_cpu_ack, o_iop_reset, o_iop_nmi, o_iop_doorbell, o_slv_xack, ok;
  logic [15:0] o_cpu_rdata, o_slv_rdata, q, lrd;
  logic [7:0] o_host_irq;
  logic o_aux_a20, o_aux_a21, o_lamp_red, o_lamp_green, o_lamp_halt;
  logic [1:0] o_aux_a22, o_aux_a23;
  logic [5:0] aux;
  pbb_local_s o_local, loc;
  pbb_bus_s o_bus, bus;
  pbb_pins_s host, cfg, pins;
  int fail_count = 0, n_tests = 0, nmi_n = 0, n0;
  always #5 i_clk = ~i_clk;
  assign cfg = '{win_base: WB, strap_lock_en: 1'h1, strap_release_each: 1'h1,
                 strap_irq_level: 3'h3, strap_a22_pos: 2'h1, strap_a23_pos: 2'h3, default: '0};
  assign pins = host | cfg;
  assign lrd = ~o_local.addr[15:0];
  always @(posedge i_clk) begin
    if (o_local.strobe) loc <= o_local;
    if (o_bus.rd | o_bus.wr) bus <= o_bus;
    if (o_bus.rd | o_bus.wr) aux <= {o_aux_a23, o_aux_a22, o_aux_a21, o_aux_a20};
    if (o_iop_nmi === 1'h1) nmi_n <= nmi_n + 1;
  end
  pbb_bridge #(.TIMEOUT_CYCLES(8)) u_pbb_bridge (.i_clk(i_clk), .i_reset(i_reset),
    .i_cpu_req(i_cpu_req), .i_cpu_we(i_cpu_we), .i_cpu_addr(i_cpu_addr),
    .i_cpu_wdata(i_cpu_wdata), .o_cpu_ack(o_cpu_ack), .o_cpu_rdata(o_cpu_rdata),
    .o_iop_reset(o_iop_reset), .o_iop_nmi(o_iop_nmi), .o_iop_doorbell(o_iop_doorbell),
    .o_local(o_local), .i_local_rdata(lrd), .i_pins(pins), .o_bus(o_bus),
    .o_slv_xack(o_slv_xack), .o_slv_rdata(o_slv_rdata), .o_host_irq(o_host_irq),
    .o_aux_a20(o_aux_a20), .o_aux_a21(o_aux_a21), .o_aux_a22(o_aux_a22),
    .o_aux_a23(o_aux_a23), .o_lamp_red(o_lamp_red), .o_lamp_green(o_lamp_green),
    .o_lamp_halt(o_lamp_halt));
  pbb_host_model u_pbb_host_model (.i_clk(i_clk), .i_bus(o_bus), .i_win(WB),
    .i_xack(o_slv_xack), .i_rdata(o_slv_rdata), .o_pins(host));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cpu(input logic we, input logic [19:0] a, input logic [15:0] d);
    int n;
    i_cpu_req = 1;
    i_cpu_we = we;
    i_cpu_addr = a;
    i_cpu_wdata = d;
    @(posedge i_clk);
    #1;
    i_cpu_req = 0;
    for (n = 0; n < 200 && o_cpu_ack !== 1'h1; n++) begin
      @(posedge i_clk);
      #1;
    end
    q = o_cpu_rdata;
  endtask
  task automatic hst(input logic wr, input logic [15:0] a, input logic [15:0] d);
    u_pbb_host_model.host(wr, {WB, a}, d, q, ok);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk(32'({o_iop_reset, o_lamp_halt, o_host_irq}), 32'h300);
    hst(1'h0, 16'hC018, 16'h0);
    chk(32'(q[7:0]), 32'h0);
  endtask
  task automatic t_host();
    hst(1'h1, 16'h8000, 16'h0002);
    chk(32'(o_iop_doorbell), 32'h1);
    hst(1'h1, 16'h4018, 16'h00DB);
    hst(1'h0, 16'h4018, 16'h0);
    chk(32'(q[7:0]), 32'hC3);
    chk(32'({o_lamp_red, o_lamp_green, o_host_irq}), 32'h308);
    hst(1'h1, 16'h4018, 16'h0020);
    repeat (4) @(posedge i_clk);
    #1;
    chk(32'({o_iop_reset, o_lamp_halt}), 32'h0);
  endtask
  task automatic t_cpu();
    cpu(1'h1, DATA_SEG_ADDR, 16'h12);
    cpu(1'h1, CODE_SEG_ADDR, 16'hC4);
    cpu(1'h0, DATA_SEG_ADDR, 16'h0);
    chk(32'(q), 32'h12);
    cpu(1'h0, 20'h03FFF, 16'h0);
    chk(32'({loc.ram_sel, q}), 32'h1C000);
    cpu(1'h1, TICK_CLR_ADDR, 16'h0);
    chk(32'({loc.tick_clr, loc.dev_sel, loc.dev_idx}), 32'h2F);
    n0 = nmi_n;
    cpu(1'h0, 20'h05000, 16'h0);
    cpu(1'h0, STATUS_ADDR, 16'h0);
    chk(32'(q[7:0]), 32'h30);
    chk(32'(nmi_n - n0), 32'h1);
    cpu(1'h1, STATUS_ADDR, 16'h0020);
    cpu(1'h0, STATUS_ADDR, 16'h0);
    chk(32'(q[7:0]), 32'h20);
  endtask
  task automatic t_bus();
    cpu(1'h0, 20'h31234, 16'h0);
    chk(32'({bus.io, bus.addr[23:16], q}), 32'h12486E);
    cpu(1'h1, 20'h1ABCD, 16'h55AA);
    chk(32'({bus.io, bus.wr, bus.addr}), 32'h312ABCD);
    u_pbb_host_model.slow = 0;
    cpu(1'h0, 20'h7FFFF, 16'h0);
    chk(32'({aux, bus.addr}), 32'h34C4FFFF);
    cpu(1'h1, DATA_SEG_ADDR, {8'h0, WB});
    cpu(1'h0, 20'h30000, 16'h0);
    chk(32'(q), 32'h0);
    cpu(1'h0, STATUS_ADDR, 16'h0);
    chk(32'(q[7:0]), 32'h30);
  endtask
  task automatic t_stop();
    hst(1'h0, 16'h4018, 16'h0);
    chk(32'(ok), 32'h0);
    hst(1'h1, 16'h8000, 16'h0020);
    repeat (4) @(posedge i_clk);
    #1;
    chk(32'({o_iop_reset, o_lamp_halt, o_bus.req}), 32'h6);
    hst(1'h0, 16'h4018, 16'h0);
    chk(32'(q[7:0]), 32'h10);
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_reset = 0;
    repeat (3) @(posedge i_clk);
    #1;
    t_reset();
    t_host();
    t_cpu();
    t_bus();
    t_stop();
    end_of_test();
  end
  // whole run is a few hundred cycles
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
